//--- design/secr_consts.vh
`ifndef SECR_CONSTS_VH
`define SECR_CONSTS_VH

// register addresses on the serial link
`define SECR_ADDR_LOCK_MEM   8'h07
`define SECR_ADDR_GENERAL    8'h08
`define SECR_ADDR_LIVE_CRC   8'h09
`define SECR_ADDR_STORED_CRC 8'h0A
`define SECR_LAST_REG        8'h3F
`define SECR_DEV_ADDR        7'h48

// lock_and_memory_status field positions
`define SECR_BIT_LOCK_LIVE   11
`define SECR_BIT_VCOBUF_POR  10
`define SECR_BIT_MEM_RD_COLL 9
`define SECR_BIT_MEM_WR_COLL 8
`define SECR_BIT_HOST_RD_ERR 7
`define SECR_BIT_HOST_WR_ERR 6
`define SECR_BIT_CRC_ERR     5
`define SECR_BIT_MEM_BUSY    4
`define SECR_BIT_CAL_DONE    3
`define SECR_BIT_CFG_DONE    2
`define SECR_BIT_UNLOCK_STK  1
`define SECR_BIT_FREQ_LOCK   0

`define SECR_RESET_WORD      16'h0000

`endif

//--- design/secr_link_events.v
`timescale 1ns/10ps
`default_nettype none

module secr_link_events (
	input  wire clk,
	input  wire resetn,
	input  wire scl,
	input  wire sda,
	output reg  scl_rise,
	output reg  scl_fall,
	output reg  bus_start,
	output reg  bus_stop
);

	reg scl_q;
	reg sda_q;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			scl_rise  <= 1'b0;
			scl_fall  <= 1'b0;
			bus_start <= 1'b0;
			bus_stop  <= 1'b0;
		end else begin
			scl_q     <= scl;
			sda_q     <= sda;
			scl_rise  <= scl & ~scl_q;
			scl_fall  <= ~scl & scl_q;
			// data edges while clock stays high frame a transfer
			bus_start <= scl & scl_q & sda_q & ~sda;
			bus_stop  <= scl & scl_q & ~sda_q & sda;
		end
	end

endmodule // secr_link_events

`default_nettype wire

//--- design/secr_status_regs.v
// Functional notes
// - bit 11 shows live PLL lock
// - bit 10 shows VCO buffer regulator POR
// - bit 9 read-phase collision, clears on read
// - bit 8 write-phase collision, clears on read
// - bit 7 flags read beyond last register
// - bit 6 flags write beyond last register
// - bit 5 set on CRC mismatch at readback
// - bit 5 cleared by commit or CRC update
// - bit 4 busy; accesses refused while busy
// - bit 3 set when calibration finished
// - bit 2 set when configuration finished
// - bit 1 sticky loss of lock
// - sticky cleared only by recalibration or reset
// - bit 0 frequency lock after calibration
// - live CRC register shows computed CRC
// - stored CRC register; compared for bit 5
`timescale 1ns/10ps
`default_nettype none
`include "secr_consts.vh"
module secr_status_regs #(
	parameter [6:0] DEV_ADDR = `SECR_DEV_ADDR,
	parameter [7:0] LAST_REG = `SECR_LAST_REG
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	input  wire        pll_lock,
	input  wire        freq_lock,
	input  wire        vcobuf_por,
	input  wire        cal_start,
	input  wire        cal_finish,
	input  wire        config_finish,
	input  wire        nvm_op_req,
	input  wire        nvm_op_is_write,
	input  wire        nvm_op_done,
	input  wire        crc_check,
	input  wire        memory_commit_command,
	input  wire        crc_update,
	input  wire [15:0] crc_live,
	input  wire [15:0] crc_stored,
	input  wire [15:0] misc_status,
	output reg         nvm_op_start,
	output reg         nvm_busy
);
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_RX    = 3'h1;
	localparam [2:0] ST_ACK   = 3'h2;
	localparam [2:0] ST_TX    = 3'h3;
	localparam [2:0] ST_MACK  = 3'h4;
	localparam [1:0] CTX_DEV  = 2'h0;
	localparam [1:0] CTX_REG  = 2'h1;
	localparam [1:0] CTX_DATA = 2'h2;
	wire [4:0] synced;
	wire       scl_f;
	wire       sda_f;
	wire       lock_live;
	wire       freq_lock_s;
	wire       por_s;
	wire       scl_rise;
	wire       scl_fall;
	wire       bus_start;
	wire       bus_stop;
	secr_sync #(
		.W       (5),
		.RST_VAL (5'h03)
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({vcobuf_por, freq_lock, pll_lock, sda_in, scl_in}),
		.sync_out (synced)
	);
	assign scl_f       = synced[0];
	assign sda_f       = synced[1];
	assign lock_live   = synced[2];
	assign freq_lock_s = synced[3];
	assign por_s       = synced[4];
	secr_link_events u_events (
		.clk       (clk),
		.resetn    (resetn),
		.scl       (scl_f),
		.sda       (sda_f),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.bus_start (bus_start),
		.bus_stop  (bus_stop)
	);
	// status state
	reg        rd_coll;
	reg        wr_coll;
	reg        host_rd_err;
	reg        host_wr_err;
	reg        crc_err;
	reg        op_is_write;
	reg        cal_done;
	reg        cfg_done;
	reg        unlock_stk;
	reg        lock_prev;
	// serial engine state
	reg [2:0]  state;
	reg [1:0]  ctx;
	reg [2:0]  bitcnt;
	reg [7:0]  rx_byte;
	reg [15:0] tx_word;
	reg [7:0]  ptr;
	reg        half;
	reg        ack_phase;
	reg        rw;
	reg        master_ack;
	reg        load_now;
	reg [7:0]  load_addr;
	reg [15:0] rd_word;
	reg [15:0] status_word;
	wire       word_written;
	wire       collide;
	wire       dev_match;
	always @* begin
		status_word = `SECR_RESET_WORD;
		status_word[`SECR_BIT_LOCK_LIVE]   = lock_live;
		status_word[`SECR_BIT_VCOBUF_POR]  = por_s;
		status_word[`SECR_BIT_MEM_RD_COLL] = rd_coll;
		status_word[`SECR_BIT_MEM_WR_COLL] = wr_coll;
		status_word[`SECR_BIT_HOST_RD_ERR] = host_rd_err;
		status_word[`SECR_BIT_HOST_WR_ERR] = host_wr_err;
		status_word[`SECR_BIT_CRC_ERR]     = crc_err;
		status_word[`SECR_BIT_MEM_BUSY]    = nvm_busy;
		status_word[`SECR_BIT_CAL_DONE]    = cal_done;
		status_word[`SECR_BIT_CFG_DONE]    = cfg_done;
		status_word[`SECR_BIT_UNLOCK_STK]  = unlock_stk;
		status_word[`SECR_BIT_FREQ_LOCK]   = cal_done & freq_lock_s;
	end
	// word fetch for the host; a read of the MSB byte takes the snapshot
	always @* begin
		load_now  = 1'b0;
		load_addr = ptr;
		if (scl_fall && state == ST_ACK && ack_phase && rw && ctx == CTX_DEV) begin
			load_now = 1'b1;
		end else if (scl_fall && state == ST_MACK && master_ack && half) begin
			load_now  = 1'b1;
			load_addr = ptr + 8'h01;
		end
		case (load_addr)
			`SECR_ADDR_LOCK_MEM:   rd_word = status_word;
			`SECR_ADDR_GENERAL:    rd_word = misc_status;
			`SECR_ADDR_LIVE_CRC:   rd_word = crc_live;
			`SECR_ADDR_STORED_CRC: rd_word = crc_stored;
			default:               rd_word = `SECR_RESET_WORD;
		endcase
	end
	assign word_written = scl_fall & (state == ST_ACK) & ~ack_phase & (ctx == CTX_DATA) & half;
	assign collide      = nvm_op_req & nvm_busy;
	assign dev_match    = (rx_byte[7:1] == DEV_ADDR);
	// memory operation tracking
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nvm_busy     <= 1'b0;
			nvm_op_start <= 1'b0;
			op_is_write  <= 1'b0;
		end else begin
			nvm_op_start <= nvm_op_req & ~nvm_busy;
			if (nvm_op_req && !nvm_busy) begin
				nvm_busy    <= 1'b1;
				op_is_write <= nvm_op_is_write;
			end else if (nvm_op_done) begin
				nvm_busy <= 1'b0;
			end
		end
	end
	// sticky flags: a set in the clearing cycle wins
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_coll     <= 1'b0;
			wr_coll     <= 1'b0;
			host_rd_err <= 1'b0;
			host_wr_err <= 1'b0;
			crc_err     <= 1'b0;
			cal_done    <= 1'b0;
			cfg_done    <= 1'b0;
			unlock_stk  <= 1'b0;
			lock_prev   <= 1'b0;
		end else begin
			lock_prev <= lock_live;
			if (collide && !op_is_write)
				rd_coll <= 1'b1;
			else if (load_now && load_addr == `SECR_ADDR_LOCK_MEM)
				rd_coll <= 1'b0;
			if (collide && op_is_write)
				wr_coll <= 1'b1;
			else if (load_now && load_addr == `SECR_ADDR_LOCK_MEM)
				wr_coll <= 1'b0;
			if (load_now && load_addr > LAST_REG)
				host_rd_err <= 1'b1;
			if (word_written && ptr > LAST_REG)
				host_wr_err <= 1'b1;
			if (crc_check && crc_live != crc_stored)
				crc_err <= 1'b1;
			else if (memory_commit_command || crc_update)
				crc_err <= 1'b0;
			if (cal_finish)
				cal_done <= 1'b1;
			else if (cal_start)
				cal_done <= 1'b0;
			if (config_finish)
				cfg_done <= 1'b1;
			// only a lock loss or a new calibration touches the sticky bit
			if (lock_prev && !lock_live)
				unlock_stk <= 1'b1;
			else if (cal_start)
				unlock_stk <= 1'b0;
		end
	end
	// serial slave: sample on clock rise, drive on clock fall
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state      <= ST_IDLE;
			ctx        <= CTX_DEV;
			bitcnt     <= 3'h0;
			rx_byte    <= 8'h00;
			tx_word    <= `SECR_RESET_WORD;
			ptr        <= 8'h00;
			half       <= 1'b0;
			ack_phase  <= 1'b0;
			rw         <= 1'b0;
			master_ack <= 1'b0;
			sda_out    <= 1'b0;
			sda_oe     <= 1'b0;
		end else if (bus_start) begin
			state     <= ST_RX;
			ctx       <= CTX_DEV;
			bitcnt    <= 3'h0;
			half      <= 1'b0;
			ack_phase <= 1'b0;
			sda_oe    <= 1'b0;
		end else if (bus_stop) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				sda_oe <= 1'b0;
			end
			ST_RX: begin
				if (scl_rise) begin
					rx_byte <= {rx_byte[6:0], sda_f};
					bitcnt  <= bitcnt + 3'h1;
					if (bitcnt == 3'h7)
						state <= ST_ACK;
				end
			end
			ST_ACK: begin
				if (scl_fall && !ack_phase) begin
					ack_phase <= 1'b1;
					case (ctx)
					CTX_DEV: begin
						sda_oe <= dev_match;
						rw     <= rx_byte[0];
						if (!dev_match)
							state <= ST_IDLE;
					end
					CTX_REG: begin
						sda_oe <= 1'b1;
						ptr    <= rx_byte;
						half   <= 1'b0;
					end
					default: begin
						// data is acknowledged but never stored here
						sda_oe <= 1'b1;
						half   <= ~half;
						if (half)
							ptr <= ptr + 8'h01;
					end
					endcase
				end else if (scl_fall) begin
					ack_phase <= 1'b0;
					bitcnt    <= 3'h0;
					if (ctx == CTX_DEV && rw) begin
						tx_word <= rd_word;
						sda_oe  <= ~rd_word[15];
						half    <= 1'b0;
						state   <= ST_TX;
					end else begin
						sda_oe <= 1'b0;
						ctx    <= (ctx == CTX_DEV) ? CTX_REG : CTX_DATA;
						state  <= ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					tx_word <= {tx_word[14:0], 1'b0};
					if (bitcnt == 3'h7) begin
						bitcnt <= 3'h0;
						sda_oe <= 1'b0;
						state  <= ST_MACK;
					end else begin
						bitcnt <= bitcnt + 3'h1;
						sda_oe <= ~tx_word[14];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					master_ack <= ~sda_f;
				end else if (scl_fall) begin
					if (!master_ack) begin
						state <= ST_IDLE;
					end else if (!half) begin
						half   <= 1'b1;
						sda_oe <= ~tx_word[15];
						state  <= ST_TX;
					end else begin
						half    <= 1'b0;
						ptr     <= load_addr;
						tx_word <= rd_word;
						sda_oe  <= ~rd_word[15];
						state   <= ST_TX;
					end
				end
			end
			default: begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end
			endcase
		end
	end

endmodule // secr_status_regs

`default_nettype wire

//--- design/secr_sync.v
`timescale 1ns/10ps
`default_nettype none

module secr_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	// output moves only when second and third stage agree
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1       <= RST_VAL;
			s2       <= RST_VAL;
			s3       <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			s1       <= async_in;
			s2       <= s1;
			s3       <= s2;
			sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
		end
	end

endmodule // secr_sync

`default_nettype wire

//--- tb/secr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "secr_consts.vh"
module secr_host_model (
	input  wire logic        clk,
	input  wire logic        sda,
	output var  logic        scl,
	output var  logic        sda_drv,
	output var  logic [15:0] word,
	output var  logic        word_ok
);
	logic r;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		word_ok = 1'b0;
	end
	// a=1 gives a start, a=0 a stop; data is set up while scl is low, then flips while scl is high
	task automatic cond(input logic a);
		@(posedge clk) scl <= 1'b0;
		repeat (4) @(posedge clk);
		sda_drv <= a;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (8) @(posedge clk);
		sda_drv <= ~a;
		repeat (8) @(posedge clk);
	endtask
	// 160 ns per bit; sampled late in the high phase, past the sync delay
	task automatic bitx(input logic d, output logic q);
		@(posedge clk) scl <= 1'b0;
		repeat (3) @(posedge clk);
		sda_drv <= d;
		repeat (5) @(posedge clk);
		scl <= 1'b1;
		repeat (7) @(posedge clk);
		q = sda;
	endtask
	task automatic xfer(input logic [7:0] b, input logic ack, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bitx(b[i], q[i]);
		bitx(ack, r);
	endtask
	// n=0 writes d at a; otherwise reads n words from a
	task automatic frame(input logic [7:0] a, input logic [15:0] d, input int n);
		logic [7:0] h;
		logic [7:0] l;
		cond(1'b1);
		xfer({`SECR_DEV_ADDR, 1'b0}, 1'b1, h);
		xfer(a, 1'b1, h);
		if (n == 0) begin
			xfer(d[15:8], 1'b1, h);
			xfer(d[7:0], 1'b1, h);
		end else begin
			cond(1'b1);
			xfer({`SECR_DEV_ADDR, 1'b1}, 1'b1, h);
		end
		for (int i = 0; i < n; i++) begin
			xfer(8'hFF, 1'b0, h);
			xfer(8'hFF, i == n - 1, l);
			@(posedge clk) word <= {h, l};
			word_ok <= 1'b1;
			@(posedge clk) word_ok <= 1'b0;
		end
		cond(1'b0);
	endtask
endmodule // secr_host_model
`default_nettype wire

//--- tb/secr_status_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module secr_status_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sda_oe,
	input wire logic nvm_op_req,
	input wire logic nvm_op_done,
	input wire logic nvm_op_start,
	input wire logic nvm_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	start_idle_a: assert property (nvm_op_req && !nvm_busy |=> nvm_op_start && nvm_busy)
		else $error("request not started");
	refuse_busy_a: assert property (nvm_op_req && nvm_busy |=> !nvm_op_start)
		else $error("request taken while busy");
	busy_hold_a: assert property (nvm_busy && !nvm_op_done |=> nvm_busy)
		else $error("busy dropped early");
	busy_clear_a: assert property (nvm_busy && nvm_op_done |=> !nvm_busy)
		else $error("busy stuck after done");
	start_once_a: assert property (nvm_op_start |=> !nvm_op_start)
		else $error("start pulse too long");
	busy_cause_a: assert property ($rose(nvm_busy) |-> $past(nvm_op_req) && nvm_op_start)
		else $error("busy without request");
	start_cause_a: assert property (nvm_op_start |-> $past(nvm_op_req) && !$past(nvm_busy))
		else $error("start without accepted request");
	ack_release_a: assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe)
		else $error("data line held too long");
endmodule // secr_status_monitor
bind secr_status_regs secr_status_monitor u_mon (.clk(clk), .resetn(resetn), .sda_oe(sda_oe),
	.nvm_op_req(nvm_op_req), .nvm_op_done(nvm_op_done), .nvm_op_start(nvm_op_start),
	.nvm_busy(nvm_busy));
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk;
	logic        resetn;
	logic [7:0]  p;
	logic [2:0]  lv;
	logic        isw;
	logic [15:0] live, stored, misc, st;
	logic [15:0] exp_q[$];
	int          n_fail;
	int          tests_run;
	int          cyc;
	wire         scl;
	wire         drv;
	wire         sda_val;
	wire         sda_oe;
	wire         sda;
	wire  [15:0] word;
	wire         word_ok;
	assign sda = drv & (~sda_oe | sda_val);
	secr_status_regs uut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_val), .sda_oe(sda_oe), .pll_lock(lv[2]), .freq_lock(lv[1]),
		.vcobuf_por(lv[0]), .cal_start(p[7]), .cal_finish(p[6]), .config_finish(p[5]),
		.nvm_op_req(p[4]), .nvm_op_is_write(isw), .nvm_op_done(p[3]), .crc_check(p[2]),
		.memory_commit_command(p[1]), .crc_update(p[0]), .crc_live(live),
		.crc_stored(stored), .misc_status(misc), .nvm_op_start(), .nvm_busy());
	secr_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(drv), .word(word),
		.word_ok(word_ok));
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic close_out;
		if (exp_q.size() != 0)
			n_fail++;
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge clk) p <= m;
		@(posedge clk) p <= 8'h00;
		repeat (6) @(posedge clk);
	endtask
	// collision bits clear once the word is read
	task automatic rstat;
		exp_q.push_back(st);
		st[9:8] = 2'b00;
		host.frame(8'h07, 16'h0000, 1);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (word_ok)
			chk(word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
		if (cyc == 40000) begin
			n_fail++;
			close_out;
		end
	end
	initial begin
		void'($urandom(57244));
		resetn = 1'b0;
		p = 8'h00;
		lv = 3'b000;
		isw = 1'b0;
		live = 16'h0000;
		stored = 16'h0000;
		misc = 16'h0000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		misc <= 16'($urandom);
		live <= 16'($urandom);
		stored <= 16'($urandom);
		lv <= 3'b111;
		repeat (8) @(posedge clk);
		st = 16'h0C00;
		exp_q.push_back(st);
		exp_q.push_back(misc);
		exp_q.push_back(live);
		exp_q.push_back(stored);
		host.frame(8'h07, 16'h0000, 4);
		host.frame(8'h08, ~misc, 0);
		exp_q.push_back(misc);
		exp_q.push_back(16'h0000);
		host.frame(8'h08, 16'h0000, 1);
		host.frame(8'h3F, 16'h0000, 1);
		pulse(8'h80);
		pulse(8'h40);
		pulse(8'h20);
		st = st | 16'h000D;
		rstat;
		@(posedge clk) lv <= 3'b001;
		repeat (12) @(posedge clk);
		st = 16'h040E;
		rstat;
		@(posedge clk) lv <= 3'b111;
		host.frame(8'h07, 16'h0000, 0);
		st = 16'h0C0F;
		rstat;
		pulse(8'h80);
		st = 16'h0C04;
		rstat;
		pulse(8'h40);
		st = 16'h0C0D;
		@(posedge clk) stored <= live ^ 16'h0100;
		for (int k = 0; k < 2; k++) begin
			pulse(8'h04);
			st[5] = 1'b1;
			rstat;
			pulse(k ? 8'h01 : 8'h02);
			st[5] = 1'b0;
			rstat;
		end
		@(posedge clk) stored <= live;
		pulse(8'h04);
		rstat;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) isw <= k[0];
			pulse(8'h10);
			pulse(8'h10);
			st[4] = 1'b1;
			st[k ? 8 : 9] = 1'b1;
			rstat;
			pulse(8'h08);
			st[4] = 1'b0;
			rstat;
		end
		host.frame(8'h40, 16'h1234, 0);
		st[6] = 1'b1;
		exp_q.push_back(16'h0000);
		host.frame(8'h40, 16'h0000, 1);
		st[7] = 1'b1;
		rstat;
		// sticky must be set before the hard reset, or its clearing goes unseen
		@(posedge clk) lv <= 3'b001;
		repeat (12) @(posedge clk);
		lv <= 3'b111;
		st[1] = 1'b1;
		rstat;
		@(posedge clk) resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk);
		st = 16'h0C00;
		rstat;
		close_out;
	end
endmodule // testbench
`default_nettype wire
